// ---- logic/serial_port_consts.svh ----
// Offsets, field positions, reset values and timing counts of the serial port front end.
// Included by the front end; holds definitions only.
`ifndef SERIAL_PORT_CONSTS_SVH
`define SERIAL_PORT_CONSTS_SVH
`define CLK_PERIOD_NS 8
`define OFS_CTRL 8'h00
`define OFS_TX_B1 8'h04
`define OFS_TX_B2 8'h08
`define OFS_RX_B1 8'h0c
`define OFS_RX_B2 8'h10
`define OFS_STATUS 8'h14
`define CTRL_LAW 0
`define CTRL_FORMAT 1
`define CTRL_LINEAR 2
`define CTRL_CHOICE 3
`define CTRL_MODE_LO 4
`define CTRL_RESET 6'h00
`define TX_RESET 16'h0000
`define SLOT_BITS_COMP 5'd8
`define SLOT_BITS_LIN 5'd16
`define DLY_COMP 11'd64
`define DLY_LIN 11'd128
`define FRAME_LOSS 11'd1024
`define BIT_CNT_LAST 11'd1
`endif

// ---- logic/serial_port_pkg.sv ----
// Types shared by the serial port front end and its bench.
// Assumes nothing of its surroundings.
package serial_port_pkg;
  typedef enum logic [1:0] {
    CODE_ADPCM,
    CODE_16K,
    CODE_BYPASS,
    CODE_SPARE
  } code_mode_t;
  typedef enum logic {
    STROBED_SERIAL,
    TDM_BACKPLANE
  } port_mode_t;
endpackage

// ---- logic/transcoder_serial_port.sv ----
// Serial voice port front end: strobed serial and backplane timing, AXI4-Lite registers.
// Assumes aclk at 125 MHz, well above the fastest pin clock, and pins that are asynchronous.
//
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "serial_port_consts.svh"

module transcoder_serial_port (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic serial_bit_clock,
  input wire logic backplane_master_clock,
  input wire logic frame_sync_in,
  input wire logic b1_slot_strobe,
  input wire logic b2_slot_strobe,
  input wire logic pcm_in_b,
  input wire logic sleep_request_n,
  output logic pcm_out_b,
  output logic pcm_out_b_oe,
  output logic delayed_frame_pulse,
  output logic delayed_frame_pulse_oe,
  output serial_port_pkg::port_mode_t port_mode,
  output logic first_port_bypass,
  output logic alaw_active,
  output logic itu_format_active,
  output logic linear_active
);
  import serial_port_pkg::*;

  function automatic logic [4:0] slot_bits(input logic lin);
    slot_bits = lin ? `SLOT_BITS_LIN : `SLOT_BITS_COMP;
  endfunction

  function automatic logic pick_bit(input logic [15:0] word, input logic lin,
                                    input logic [4:0] idx);
    logic [4:0] pos;
    pos = slot_bits(lin) - 5'd1 - idx;
    pick_bit = word[pos[3:0]];
  endfunction

  // Backplane slot and bit position of a bit index; linear slots are twice as long.
  function automatic logic [4:0] slot_of(input logic [9:0] b, input logic lin);
    slot_of = lin ? b[8:4] : b[7:3];
  endfunction

  function automatic logic [4:0] pos_of(input logic [9:0] b, input logic lin);
    pos_of = lin ? {1'b0, b[3:0]} : {2'b00, b[2:0]};
  endfunction

  // A companded word fills the low byte only, so bits of an earlier slot must not linger.
  function automatic logic [15:0] rx_word(input logic [15:0] sh, input logic lin);
    rx_word = lin ? sh : {8'h00, sh[7:0]};
  endfunction

  // Pin synchronisers; stage one feeds stage two only, stage three is for edges.
  logic [6:0] pin_s1_reg;
  logic [6:0] pin_s2_reg;
  logic [6:0] pin_s3_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_reg <= 7'h00;
      pin_s2_reg <= 7'h00;
      pin_s3_reg <= 7'h00;
    end else begin
      pin_s1_reg <= {sleep_request_n, pcm_in_b, b2_slot_strobe, b1_slot_strobe,
                     frame_sync_in, backplane_master_clock, serial_bit_clock};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end

  logic sb_rise, sb_fall, mc_rise, mc_fall, fs_rise;
  logic str1, str2, din, awake;
  assign sb_rise = pin_s2_reg[0] && !pin_s3_reg[0];
  assign sb_fall = !pin_s2_reg[0] && pin_s3_reg[0];
  assign mc_rise = pin_s2_reg[1] && !pin_s3_reg[1];
  assign mc_fall = !pin_s2_reg[1] && pin_s3_reg[1];
  assign fs_rise = pin_s2_reg[2] && !pin_s3_reg[2];
  assign str1 = pin_s2_reg[3];
  assign str2 = pin_s2_reg[4];
  assign din = pin_s2_reg[5];
  assign awake = pin_s2_reg[6];

  // Sleep acts as a reset of all port logic after the pin synchronisers; control and transmit registers keep their contents, received words clear.
  logic core_rst;
  assign core_rst = !aresetn || !awake;

  logic [5:0] ctrl_reg;
  logic [15:0] tx_b1_reg, tx_b2_reg, rx_b1_reg, rx_b2_reg;
  logic lin, choice;
  code_mode_t code_mode;
  assign lin = ctrl_reg[`CTRL_LINEAR];
  assign choice = ctrl_reg[`CTRL_CHOICE];
  assign code_mode = code_mode_t'(ctrl_reg[`CTRL_MODE_LO +: 2]);

  // Slots that carry this device's words in the selected coding mode.
  logic use_b1, use_b2;
  always_comb begin
    use_b1 = 1'b1;
    use_b2 = 1'b1;
    if (code_mode == CODE_16K) begin
      use_b1 = !choice;
      use_b2 = choice;
    end else if (code_mode == CODE_BYPASS) begin
      use_b1 = choice;
      use_b2 = choice;
    end
  end

  always_ff @(posedge aclk) begin
    if (core_rst) begin
      alaw_active <= 1'b0;
      itu_format_active <= 1'b0;
      linear_active <= 1'b0;
      first_port_bypass <= 1'b0;
    end else begin
      alaw_active <= !lin && ctrl_reg[`CTRL_LAW];
      itu_format_active <= !lin && ctrl_reg[`CTRL_FORMAT];
      linear_active <= lin;
      first_port_bypass <= (code_mode == CODE_BYPASS) && !choice;
    end
  end

  // Mode follows frame sync: pulses keep backplane mode, a quiet line drops to strobed.
  logic [10:0] mc_cnt_reg;
  always_ff @(posedge aclk) begin
    if (core_rst) begin
      port_mode <= STROBED_SERIAL;
      mc_cnt_reg <= 11'h000;
    end else if (fs_rise) begin
      port_mode <= TDM_BACKPLANE;
      mc_cnt_reg <= 11'h000;
    end else if (mc_rise && mc_cnt_reg != `FRAME_LOSS) begin
      mc_cnt_reg <= mc_cnt_reg + 11'd1;
    end else if (mc_cnt_reg == `FRAME_LOSS) begin
      port_mode <= STROBED_SERIAL;
    end
  end

  logic tdm;
  assign tdm = (port_mode == TDM_BACKPLANE);

  // Backplane timing: each bit spans two master clocks, so halving the count gives the bit index.
  logic [9:0] bit_idx, nxt_bit;
  logic [4:0] tdm_pos, tdm_slot, nxt_pos, nxt_slot;
  assign bit_idx = mc_cnt_reg[10:1];
  // Frame sync starts bit 0; otherwise the bit after the current one is launched next.
  assign nxt_bit = fs_rise ? 10'h000 : bit_idx + 10'h001;
  assign tdm_slot = slot_of(bit_idx, lin);
  assign tdm_pos = pos_of(bit_idx, lin);
  assign nxt_slot = slot_of(nxt_bit, lin);
  assign nxt_pos = pos_of(nxt_bit, lin);

  logic tdm_in_reg;
  logic [15:0] tdm_sh_reg;
  always_ff @(posedge aclk) begin
    if (core_rst) begin
      tdm_in_reg <= 1'b0;
      tdm_sh_reg <= 16'h0000;
    end else if (tdm && mc_fall && mc_cnt_reg[0]) begin
      tdm_in_reg <= din;
      tdm_sh_reg <= {tdm_sh_reg[14:0], din};
    end
  end

  // Strobed capture: data and strobes share the falling serial clock edge.
  logic str1_q_reg, str2_q_reg;
  logic [15:0] ser_sh_reg;
  logic [4:0] ser_cnt_reg;
  always_ff @(posedge aclk) begin
    if (core_rst) begin
      str1_q_reg <= 1'b0;
      str2_q_reg <= 1'b0;
      ser_sh_reg <= 16'h0000;
    end else if (!tdm && sb_fall) begin
      str1_q_reg <= str1;
      str2_q_reg <= str2;
      if (str1 || str2) begin
        ser_sh_reg <= {ser_sh_reg[14:0], din};
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (core_rst) begin
      rx_b1_reg <= 16'h0000;
      rx_b2_reg <= 16'h0000;
    end else if (!tdm && sb_fall) begin
      if (str1_q_reg && !str1) begin
        rx_b1_reg <= rx_word(ser_sh_reg, lin);
      end
      if (str2_q_reg && !str2) begin
        rx_b2_reg <= rx_word(ser_sh_reg, lin);
      end
    end else if (tdm && mc_rise && mc_cnt_reg[0] && tdm_pos == slot_bits(lin) - 5'd1) begin
      if (tdm_slot == 5'd0) begin
        rx_b1_reg <= rx_word(tdm_sh_reg, lin);
      end else if (tdm_slot == 5'd1) begin
        rx_b2_reg <= rx_word(tdm_sh_reg, lin);
      end
    end
  end

  // Strobed launch: bit count restarts whenever neither strobe is high.
  always_ff @(posedge aclk) begin
    if (core_rst) begin
      ser_cnt_reg <= 5'd0;
    end else if (!tdm && sb_rise) begin
      if (!(str1 || str2)) begin
        ser_cnt_reg <= 5'd0;
      end else if (ser_cnt_reg != slot_bits(lin)) begin
        ser_cnt_reg <= ser_cnt_reg + 5'd1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (core_rst) begin
      pcm_out_b <= 1'b0;
      pcm_out_b_oe <= 1'b0;
    end else if (!tdm) begin
      if (sb_rise) begin
        pcm_out_b_oe <= (str1 && use_b1) || (str2 && use_b2);
        pcm_out_b <= str2 ? pick_bit(tx_b2_reg, lin, ser_cnt_reg)
                          : pick_bit(tx_b1_reg, lin, ser_cnt_reg);
      end
    end else if (fs_rise || (mc_rise && mc_cnt_reg[0])) begin
      // A new bit period starts here; frame sync launches bit 0 of slot 0.
      if (nxt_slot == 5'd0) begin
        pcm_out_b_oe <= use_b1;
        pcm_out_b <= pick_bit(tx_b1_reg, lin, nxt_pos);
      end else if (nxt_slot == 5'd1) begin
        pcm_out_b_oe <= use_b2;
        pcm_out_b <= pick_bit(tx_b2_reg, lin, nxt_pos);
      end else if (nxt_slot == 5'd2 || nxt_slot == 5'd3) begin
        // Slots 2 and 3 are D and C, passed with one bit of delay while the B1 strobe pin is low.
        pcm_out_b_oe <= !str1;
        pcm_out_b <= tdm_in_reg;
      end else begin
        pcm_out_b_oe <= 1'b0;
      end
    end
  end

  // Delayed frame pulse lasts one master clock; it shares the B2 strobe pin.
  logic [10:0] dly;
  assign dly = lin ? `DLY_LIN : `DLY_COMP;
  always_ff @(posedge aclk) begin
    if (core_rst || !tdm) begin
      delayed_frame_pulse <= 1'b0;
      delayed_frame_pulse_oe <= 1'b0;
    end else begin
      delayed_frame_pulse_oe <= 1'b1;
      if (mc_rise) begin
        delayed_frame_pulse <= (mc_cnt_reg + 11'd1 == dly);
      end
    end
  end

  // AXI4-Lite write: address and data are held independently until both are in.
  logic aw_full_reg, w_full_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  assign s_axi_awready = !aw_full_reg;
  assign s_axi_wready = !w_full_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (s_axi_bvalid && s_axi_bready) begin
        aw_full_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (s_axi_bvalid && s_axi_bready) begin
        w_full_reg <= 1'b0;
      end
    end
  end

  logic do_write, addr_ok;
  assign do_write = aw_full_reg && w_full_reg && !s_axi_bvalid;
  assign addr_ok = aw_addr_reg == `OFS_CTRL || aw_addr_reg == `OFS_TX_B1
                   || aw_addr_reg == `OFS_TX_B2;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      ctrl_reg <= `CTRL_RESET;
      tx_b1_reg <= `TX_RESET;
      tx_b2_reg <= `TX_RESET;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= addr_ok ? 2'b00 : 2'b10;
      if (aw_addr_reg == `OFS_CTRL) begin
        if (w_strb_reg[0]) ctrl_reg <= w_data_reg[5:0];
      end else if (aw_addr_reg == `OFS_TX_B1) begin
        if (w_strb_reg[0]) tx_b1_reg[7:0] <= w_data_reg[7:0];
        if (w_strb_reg[1]) tx_b1_reg[15:8] <= w_data_reg[15:8];
      end else if (aw_addr_reg == `OFS_TX_B2) begin
        if (w_strb_reg[0]) tx_b2_reg[7:0] <= w_data_reg[7:0];
        if (w_strb_reg[1]) tx_b2_reg[15:8] <= w_data_reg[15:8];
      end
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // AXI4-Lite read: one cycle from the address handshake to valid data.
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      if (s_axi_araddr == `OFS_CTRL) begin
        s_axi_rdata <= {26'h0, ctrl_reg};
      end else if (s_axi_araddr == `OFS_TX_B1) begin
        s_axi_rdata <= {16'h0, tx_b1_reg};
      end else if (s_axi_araddr == `OFS_TX_B2) begin
        s_axi_rdata <= {16'h0, tx_b2_reg};
      end else if (s_axi_araddr == `OFS_RX_B1) begin
        s_axi_rdata <= {16'h0, rx_b1_reg};
      end else if (s_axi_araddr == `OFS_RX_B2) begin
        s_axi_rdata <= {16'h0, rx_b2_reg};
      end else if (s_axi_araddr == `OFS_STATUS) begin
        s_axi_rdata <= {27'h0, first_port_bypass, itu_format_active, alaw_active,
                        !awake, tdm};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= 2'b10;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// ---- verification/port_chk_sva.sv ----
// Concurrent checks on the ports of the serial port front end.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/10ps
module port_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sleep_request_n,
  input wire logic pcm_out_b_oe,
  input wire logic delayed_frame_pulse,
  input wire logic delayed_frame_pulse_oe,
  input wire logic first_port_bypass,
  input wire logic alaw_active,
  input wire logic itu_format_active,
  input wire logic linear_active
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |=> ##1 s_axi_bvalid) else $error("write response missing");
  chk_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data missing");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  // Six cycles cover the pin synchroniser and the output register.
  chk_sleep_float: assert property (!sleep_request_n [*6] |->
    !pcm_out_b_oe && !delayed_frame_pulse_oe) else $error("outputs driven in sleep");
  chk_linear_ignores: assert property (linear_active |->
    !alaw_active && !itu_format_active) else $error("law or format active in linear");
  chk_bypass_float: assert property (first_port_bypass |-> !pcm_out_b_oe)
    else $error("second port driven in first port bypass");
  chk_pulse_width: assert property ($rose(delayed_frame_pulse) |->
    (delayed_frame_pulse && delayed_frame_pulse_oe) [*8]) else $error("short frame pulse");
  cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h2);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property ($rose(delayed_frame_pulse));
endmodule

bind transcoder_serial_port port_chk chk_u (.*);

// ---- verification/serial_partner.sv ----
// Behavioural codec on the second serial port, in strobed and backplane timing.
// Assumes one task at a time is called; its clocks stand still between calls.
`timescale 1ns/10ps
module serial_partner (
  output logic serial_bit_clock,
  output logic backplane_master_clock,
  output logic frame_sync_in,
  output logic b1_slot_strobe,
  output logic b2_slot_strobe,
  output logic pcm_in_b,
  input wire logic pcm_out_b,
  input wire logic pcm_out_b_oe,
  input wire logic delayed_frame_pulse
);
  initial {serial_bit_clock, backplane_master_clock, frame_sync_in} = 3'h0;
  initial {b1_slot_strobe, b2_slot_strobe, pcm_in_b} = 3'h0;

  // A floating line reads as z, so an undriven slot never passes for data.
  // Data settle 104 ns after a fall and hold past the next fall.
  task automatic slot(input logic s2, input logic [7:0] din, output logic [7:0] dout);
    #2;
    for (int i = 7; i >= 0; i--) begin
      #104 b1_slot_strobe = !s2;
      b2_slot_strobe = s2;
      pcm_in_b = din[i];
      #96 serial_bit_clock = 1'b1;
      #192 dout[i] = pcm_out_b_oe ? pcm_out_b : 1'bz;
      #8 serial_bit_clock = 1'b0;
    end
    #104 {b1_slot_strobe, b2_slot_strobe} = 2'h0;
    pcm_in_b = !din[0];
    #96 serial_bit_clock = 1'b1;
    #200 serial_bit_clock = 1'b0;
    #200;
  endtask

  // One frame of 256 master clocks; k is the first rise after which the pulse shows.
  task automatic frame(input logic b1, output int k, output logic dc, output logic [7:0] bq);
    #2;
    k = 0;
    b1_slot_strobe = b1;
    frame_sync_in = 1'b1;
    for (int i = 1; i <= 256; i++) begin
      #120 backplane_master_clock = 1'b1;
      pcm_in_b = !pcm_in_b;
      #96 if (delayed_frame_pulse && k == 0) k = i;
      if (i == 40) dc = pcm_out_b_oe;
      if (i < 16 && i[0]) bq = {bq[6:0], pcm_out_b_oe ? pcm_out_b : 1'bz};
      #32 backplane_master_clock = 1'b0;
      frame_sync_in = 1'b0;
    end
  endtask
endmodule

// ---- verification/transcoder_serial_port_tb.sv ----
// Self-checking bench of the serial port front end with a codec model on its pins.
// Assumes the design, the checker and the partner model are compiled first.
`timescale 1ns/10ps
module transcoder_serial_port_tb;
  import serial_port_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, serial_bit_clock, backplane_master_clock, frame_sync_in;
  logic b1_slot_strobe, b2_slot_strobe, pcm_in_b, sleep_request_n, pcm_out_b;
  logic pcm_out_b_oe, delayed_frame_pulse, delayed_frame_pulse_oe, first_port_bypass;
  logic alaw_active, itu_format_active, linear_active, dc;
  logic [7:0] s_axi_awaddr, s_axi_araddr, got, bq;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  port_mode_t port_mode;
  int miscompares, cmp_count, cyc, k;

  transcoder_serial_port dut_u (.*);
  serial_partner part_u (.*);

  initial begin
    aclk = 1'b0;
    forever #4 aclk = !aclk;
  end

  // The run needs about 35000 cycles.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 70000) begin
      miscompares++;
      conclude();
    end
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input string n, input logic [31:0] e, input logic [31:0] a);
    cmp_count++;
    if (a !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, a);
    end
  endtask

  // Responses are taken one cycle late on purpose, so the slave must hold them.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
    check("bresp", er, s_axi_bresp);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
    check("rdata", ed, s_axi_rdata);
    check("rresp", er, s_axi_rresp);
  endtask

  task automatic t_regs();
    wr(8'h00, 32'h0000_0003, 2'h0);
    rd(8'h00, 32'h0000_0003, 2'h0);
    check("alaw", 1'b1, alaw_active);
    check("itu", 1'b1, itu_format_active);
    wr(8'h00, 32'h0000_0007, 2'h0);
    repeat (3) @(posedge aclk);
    check("lin", 1'b1, linear_active);
    check("law_lin", 2'h0, {alaw_active, itu_format_active});
    wr(8'h0c, 32'h0000_0001, 2'h2);
    rd(8'h40, 32'h0000_0000, 2'h2);
    wr(8'h00, 32'h0000_0000, 2'h0);
    repeat (3) @(posedge aclk);
    check("mulaw", 2'h0, {alaw_active, itu_format_active});
    $display("test regs done");
  endtask

  task automatic t_strobed();
    wr(8'h04, 32'h0000_00a5, 2'h0);
    wr(8'h08, 32'h0000_005a, 2'h0);
    part_u.slot(1'b0, 8'h3c, got);
    check("b1_out", 8'ha5, got);
    rd(8'h0c, 32'h0000_003c, 2'h0);
    part_u.slot(1'b1, 8'hc3, got);
    check("b2_out", 8'h5a, got);
    rd(8'h10, 32'h0000_00c3, 2'h0);
    check("mode", STROBED_SERIAL, port_mode);
    wr(8'h00, 32'h0000_0018, 2'h0);
    part_u.slot(1'b0, 8'h11, got);
    check("b1_16k", 8'hzz, got);
    part_u.slot(1'b1, 8'h22, got);
    check("b2_16k", 8'h5a, got);
    wr(8'h00, 32'h0000_0020, 2'h0);
    part_u.slot(1'b1, 8'h33, got);
    check("byp_first", 8'hzz, got);
    check("byp_flag1", 1'b1, first_port_bypass);
    wr(8'h00, 32'h0000_0028, 2'h0);
    check("byp_flag2", 1'b0, first_port_bypass);
    part_u.slot(1'b1, 8'h44, got);
    check("byp_second", 8'h5a, got);
    $display("test strobed done");
  endtask

  task automatic t_backplane();
    wr(8'h00, 32'h0000_0000, 2'h0);
    part_u.frame(1'b0, k, dc, bq);
    part_u.frame(1'b0, k, dc, bq);
    check("dfp_comp", 64, k);
    check("dc_pass", 1'b1, dc);
    check("b1_bits", 8'ha5, bq);
    check("mode_bp", TDM_BACKPLANE, port_mode);
    check("dfp_oe", 1'b1, delayed_frame_pulse_oe);
    part_u.frame(1'b1, k, dc, bq);
    check("dc_float", 1'b0, dc);
    wr(8'h00, 32'h0000_0004, 2'h0);
    part_u.frame(1'b0, k, dc, bq);
    check("dfp_lin", 128, k);
    // The model toggles the input at every master rise, so each 3/4 sample reads low.
    rd(8'h0c, 32'h0000_0000, 2'h0);
    $display("test backplane done");
  endtask

  task automatic t_sleep();
    @(posedge aclk);
    sleep_request_n <= 1'b0;
    repeat (8) @(posedge aclk);
    check("oe_sleep", 2'h0, {pcm_out_b_oe, delayed_frame_pulse_oe});
    rd(8'h14, 32'h0000_0002, 2'h0);
    sleep_request_n <= 1'b1;
    $display("test sleep done");
  endtask

  initial begin
    miscompares = 0;
    cmp_count = 0;
    cyc = 0;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    sleep_request_n = 1'b1;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_strobed();
    t_backplane();
    t_sleep();
    conclude();
  end
endmodule
